// ==== shared/mpp_pkg.sv ====
// constants, modes and register selects for the multimode parallel ports
package mpp_pkg;
  localparam int PORT_W    = 8;
  localparam int SERIAL_PORT_LATCH_W   = 6;
  localparam int CS_W      = 4;
  localparam int ADDR_W    = 16;
  localparam int SEL_W     = 4;
  localparam int CNT_W     = 4;
  localparam int E_PHASE   = 2;
  localparam logic [PORT_W-1:0]  LATCH_RST = 8'h00;
  localparam logic [PORT_W-1:0]  DIR_RST   = 8'h00;
  localparam logic [SERIAL_PORT_LATCH_W-1:0] DIRD_RST  = 6'h00;
  localparam logic [ADDR_W-1:0]  ADDR_RST  = 16'h0000;

  typedef enum logic [1:0] {
    MODE_BOOT   = 2'h0,
    MODE_TEST   = 2'h1,
    MODE_SINGLE = 2'h2,
    MODE_EXPAND = 2'h3
  } mpp_mode_e;

  typedef enum logic [SEL_W-1:0] {
    SEL_A_DATA = 4'h0,
    SEL_A_DIR  = 4'h1,
    SEL_B_DATA = 4'h2,
    SEL_C_DATA = 4'h3,
    SEL_C_DIR  = 4'h4,
    SEL_D_DATA = 4'h5,
    SEL_D_DIR  = 4'h6,
    SEL_E_DATA = 4'h7,
    SEL_F_DATA = 4'h8,
    SEL_G_DATA = 4'h9,
    SEL_G_DIR  = 4'hA
  } mpp_sel_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_ELOW  = 2'h1,
    ST_EHIGH = 2'h3
  } mpp_bus_st_e;
endpackage : mpp_pkg

// ==== shared/mpp_bus_if.sv ====
// link between the port top and the external bus cycle sequencer
`timescale 1ns/1ns
interface mpp_bus_if;
  import mpp_pkg::*;
  logic              req;
  logic              write;
  logic [ADDR_W-1:0] addr;
  logic [PORT_W-1:0] wdata;
  logic [PORT_W-1:0] pinData;
  logic              enable;
  logic              ready;
  logic              done;
  logic [PORT_W-1:0] rdata;
  logic              eClk;
  logic              rw;
  logic              dataOe;
  logic [PORT_W-1:0] ddata;
  logic [ADDR_W-1:0] addrOut;
  modport core (output req, write, addr, wdata, pinData, enable,
                input ready, done, rdata, eClk, rw, dataOe, ddata, addrOut);
  modport seq  (input req, write, addr, wdata, pinData, enable,
                output ready, done, rdata, eClk, rw, dataOe, ddata, addrOut);
endinterface : mpp_bus_if

// ==== verilog/mpp_pad.sv ====
// per-port pad logic: driver source, enables, open-drain and read-back
`timescale 1ns/1ns
module mpp_pad
  import mpp_pkg::*;
#(
  parameter int W = 8
)(
  input  wire logic [W-1:0] latch,
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] altOwn,
  input  wire logic [W-1:0] altVal,
  input  wire logic [W-1:0] altDrive,
  input  wire logic         openDrain,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] outVal,
  output logic      [W-1:0] oeN,
  output logic      [W-1:0] readVal
);
  logic [W-1:0] drv;
  logic [W-1:0] en;

  always_comb
  begin
    drv     = (altOwn & altVal) | (~altOwn & latch);
    en      = (altOwn & altDrive) | (~altOwn & dir);
    // high-side off: a one floats, a zero pulls low
    oeN     = ~(en & ~({W{openDrain}} & drv));
    outVal  = drv & ~{W{openDrain}};
    readVal = (en & drv) | (~en & pin);
  end
endmodule : mpp_pad

// ==== verilog/mpp_ext_bus.sv ====
// external bus cycle sequencer: e clock phases, read/write line, data capture
`timescale 1ns/1ns
module mpp_ext_bus
  import mpp_pkg::*;
#(
  parameter int PHASE = E_PHASE
)(
  input  wire logic core_clk,
  input  wire logic arst_n,
  mpp_bus_if.seq    bus
);
  mpp_bus_st_e       state_r, state_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic              pend_r, pend_nxt;
  logic              pendWr_r, pendWr_nxt;
  logic [ADDR_W-1:0] pendAddr_r, pendAddr_nxt;
  logic [PORT_W-1:0] pendData_r, pendData_nxt;
  logic              wr_r, wr_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [PORT_W-1:0] data_r, data_nxt;
  logic [PORT_W-1:0] rdata_r, rdata_nxt;
  logic              e_r, e_nxt;
  logic              rw_r, rw_nxt;
  logic              done_r, done_nxt;
  logic              last;

  always_comb
  begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    pend_nxt     = pend_r;
    pendWr_nxt   = pendWr_r;
    pendAddr_nxt = pendAddr_r;
    pendData_nxt = pendData_r;
    wr_nxt       = wr_r;
    addr_nxt     = addr_r;
    data_nxt     = data_r;
    rdata_nxt    = rdata_r;
    e_nxt        = e_r;
    rw_nxt       = rw_r;
    done_nxt     = 1'b0;
    last         = (cnt_r == CNT_W'(PHASE - 1));
    if (bus.req && !pend_r && bus.enable)
    begin
      pend_nxt     = 1'b1;
      pendWr_nxt   = bus.write;
      pendAddr_nxt = bus.addr;
      pendData_nxt = bus.wdata;
    end
    case (state_r)
      ST_IDLE:
      begin
        rw_nxt = 1'b1;
        e_nxt  = 1'b0;
        if (pend_r)
        begin
          pend_nxt  = 1'b0;
          wr_nxt    = pendWr_r;
          addr_nxt  = pendAddr_r;
          data_nxt  = pendData_r;
          rw_nxt    = ~pendWr_r;
          cnt_nxt   = '0;
          state_nxt = ST_ELOW;
        end
      end
      ST_ELOW:
      begin
        cnt_nxt = cnt_r + CNT_W'(1);
        if (last)
        begin
          cnt_nxt   = '0;
          e_nxt     = 1'b1;
          state_nxt = ST_EHIGH;
        end
      end
      ST_EHIGH:
      begin
        cnt_nxt = cnt_r + CNT_W'(1);
        if (last)
        begin
          cnt_nxt  = '0;
          e_nxt    = 1'b0;
          done_nxt = 1'b1;
          if (!wr_r)
            rdata_nxt = bus.pinData;
          if (pend_r)
          begin
            // next cycle starts at once; a write after a write keeps the line low
            pend_nxt  = 1'b0;
            wr_nxt    = pendWr_r;
            addr_nxt  = pendAddr_r;
            data_nxt  = pendData_r;
            rw_nxt    = ~pendWr_r;
            state_nxt = ST_ELOW;
          end
          else
          begin
            rw_nxt    = 1'b1;
            state_nxt = ST_IDLE;
          end
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
        rw_nxt    = 1'b1;
        e_nxt     = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r    <= ST_IDLE;
      cnt_r      <= '0;
      pend_r     <= 1'b0;
      pendWr_r   <= 1'b0;
      pendAddr_r <= ADDR_RST;
      pendData_r <= LATCH_RST;
      wr_r       <= 1'b0;
      addr_r     <= ADDR_RST;
      data_r     <= LATCH_RST;
      rdata_r    <= LATCH_RST;
      e_r        <= 1'b0;
      rw_r       <= 1'b1;
      done_r     <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      pend_r     <= pend_nxt;
      pendWr_r   <= pendWr_nxt;
      pendAddr_r <= pendAddr_nxt;
      pendData_r <= pendData_nxt;
      wr_r       <= wr_nxt;
      addr_r     <= addr_nxt;
      data_r     <= data_nxt;
      rdata_r    <= rdata_nxt;
      e_r        <= e_nxt;
      rw_r       <= rw_nxt;
      done_r     <= done_nxt;
    end
  end

  assign bus.ready   = ~pend_r;
  assign bus.done    = done_r;
  assign bus.rdata   = rdata_r;
  assign bus.eClk    = e_r;
  assign bus.rw      = rw_r;
  assign bus.dataOe  = ~rw_r;
  assign bus.ddata   = data_r;
  assign bus.addrOut = addr_r;
endmodule : mpp_ext_bus

// ==== verilog/mpp_ports.sv ====
// top of the multimode parallel ports: latches, directions, pin ownership
// How it works
// - in expanded and test modes read/write line stays high through each read cycle.
// - read/write stays low across back-to-back external write cycles.
// - fifty-four pins: six eight-bit ports and one six-bit port.
// - ports A, C, D, G bidirectional; B, F output only; E input only.
// - B, C, F are I/O only in single-chip and boot; else address and data.
// - bidirectional read returns pin for inputs, driver input for outputs.
// - port A writes latch always, drive outputs only, not timer-owned pins.
// - after reset all port A pins are high-impedance inputs.
// - with its timer function off, a port A pin follows its direction bit.
// - on the first clock after reset release the A, C, D and G data latches take the port's logic levels.
// - reading B and F returns the data latch, in every mode.
// - B and F writes latch in every mode, drive pins in single-chip or boot.
// - port C inputs after reset in single-chip and boot, data bus otherwise.
// - port C open-drain: zero pulls low, one floats.
// - port C open-drain only in single-chip or boot mode.
// - port D shared with serial and SPI; latch drives only general outputs.
// - port D open-drain select works in every mode.
// - four chip selects replace general use of port G bits 7 to 4.
// - port G open-drain select works in every mode.
`timescale 1ns/1ns
module mpp_ports
  import mpp_pkg::*;
#(
  parameter int PHASE = E_PHASE
)(
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  input  wire logic                modeSelectPinLow,
  input  wire logic                modeSelectPinHigh,
  input  wire logic                regWrEn,
  input  wire logic                regRdEn,
  input  wire logic [SEL_W-1:0]    regSel,
  input  wire logic [PORT_W-1:0]   regWrData,
  output logic      [PORT_W-1:0]   regRdData,
  output logic                     regRdValid,
  input  wire logic                busReq,
  input  wire logic                busWrite,
  input  wire logic [ADDR_W-1:0]   busAddr,
  input  wire logic [PORT_W-1:0]   busWrData,
  output logic                     busReady,
  output logic                     busDone,
  output logic      [PORT_W-1:0]   busRdData,
  input  wire logic [PORT_W-1:0]   timerOcOwn,
  input  wire logic [PORT_W-1:0]   timerOcVal,
  input  wire logic [SERIAL_PORT_LATCH_W-1:0]  serialOwn,
  input  wire logic [SERIAL_PORT_LATCH_W-1:0]  serialVal,
  input  wire logic [SERIAL_PORT_LATCH_W-1:0]  serialDrive,
  input  wire logic                dOpenDrainSelect,
  input  wire logic [CS_W-1:0]     chipSelectEn,
  input  wire logic [CS_W-1:0]     chipSelectVal,
  input  wire logic                cOpenDrainSelect,
  input  wire logic                gOpenDrainSelect,
  input  wire logic [PORT_W-1:0]   portAIn,
  input  wire logic [PORT_W-1:0]   portCIn,
  input  wire logic [SERIAL_PORT_LATCH_W-1:0]  portDIn,
  input  wire logic [PORT_W-1:0]   analogInputPort,
  input  wire logic [PORT_W-1:0]   portGIn,
  output logic      [PORT_W-1:0]   portAOut,
  output logic      [PORT_W-1:0]   portAOeN,
  output logic      [PORT_W-1:0]   portBOut,
  output logic      [PORT_W-1:0]   portCOut,
  output logic      [PORT_W-1:0]   portCOeN,
  output logic      [SERIAL_PORT_LATCH_W-1:0]  portDOut,
  output logic      [SERIAL_PORT_LATCH_W-1:0]  portDOeN,
  output logic      [PORT_W-1:0]   portFOut,
  output logic      [PORT_W-1:0]   portGOut,
  output logic      [PORT_W-1:0]   portGOeN,
  output logic                     eClkPin,
  output logic                     rwPin,
  output logic      [1:0]          opMode
);
  mpp_bus_if busIf();

  // mode and start-up capture
  logic               started_r, started_nxt;
  mpp_mode_e          mode_r, mode_nxt;
  logic               expanded;
  // data latches and direction registers
  logic [PORT_W-1:0]  firstPortLatch_r, firstPortLatch_nxt;
  logic [PORT_W-1:0]  firstPortDirection_r, firstPortDirection_nxt;
  logic [PORT_W-1:0]  highAddressPortLatch_r, highAddressPortLatch_nxt;
  logic [PORT_W-1:0]  dataBusPortLatch_r, dataBusPortLatch_nxt;
  logic [PORT_W-1:0]  dataBusPortDirection_r, dataBusPortDirection_nxt;
  logic [SERIAL_PORT_LATCH_W-1:0] serialPortLatch_r, serialPortLatch_nxt;
  logic [SERIAL_PORT_LATCH_W-1:0] serialPortDirection_r, serialPortDirection_nxt;
  logic [PORT_W-1:0]  lowAddressPortLatch_r, lowAddressPortLatch_nxt;
  logic [PORT_W-1:0]  chipSelectPortLatch_r, chipSelectPortLatch_nxt;
  logic [PORT_W-1:0]  chipSelectPortDirection_r, chipSelectPortDirection_nxt;
  // pad results
  logic [PORT_W-1:0]  aOut, aOeN, aRead;
  logic [PORT_W-1:0]  cOut, cOeN, cRead;
  logic [SERIAL_PORT_LATCH_W-1:0] dOut, dOeN, dRead;
  logic [PORT_W-1:0]  gOut, gOeN, gRead;
  logic [PORT_W-1:0]  cOwn, cDrive, gOwn, gVal, gDrive;
  logic               c_open_drain_select;
  // registered outputs
  logic [PORT_W-1:0]  rdData_r, rdData_nxt;
  logic               rdValid_r;
  logic [PORT_W-1:0]  aOut_r, aOeN_r, bOut_r, cOut_r, cOeN_r, fOut_r, gOut_r, gOeN_r;
  logic [SERIAL_PORT_LATCH_W-1:0] dOut_r, dOeN_r;
  logic [PORT_W-1:0]  bNxt, fNxt;
  logic               e_r, rw_r, rwNxt;
  logic               busReady_r, busDone_r;
  logic [PORT_W-1:0]  busRdData_r;

  function automatic logic isExpanded(input mpp_mode_e m);
    isExpanded = (m == MODE_EXPAND) || (m == MODE_TEST);
  endfunction : isExpanded

  // mode pins are caught on the first clock after reset release
  always_comb
  begin
    started_nxt = 1'b1;
    mode_nxt    = started_r ? mode_r : mpp_mode_e'({modeSelectPinHigh, modeSelectPinLow});
    expanded    = started_r && isExpanded(mode_r);
  end

  // register writes; the first clock also loads latches from the pins
  always_comb
  begin
    firstPortLatch_nxt          = firstPortLatch_r;
    firstPortDirection_nxt      = firstPortDirection_r;
    highAddressPortLatch_nxt    = highAddressPortLatch_r;
    dataBusPortLatch_nxt        = dataBusPortLatch_r;
    dataBusPortDirection_nxt    = dataBusPortDirection_r;
    serialPortLatch_nxt         = serialPortLatch_r;
    serialPortDirection_nxt     = serialPortDirection_r;
    lowAddressPortLatch_nxt     = lowAddressPortLatch_r;
    chipSelectPortLatch_nxt     = chipSelectPortLatch_r;
    chipSelectPortDirection_nxt = chipSelectPortDirection_r;
    if (!started_r)
    begin
      firstPortLatch_nxt      = portAIn;
      dataBusPortLatch_nxt    = portCIn;
      serialPortLatch_nxt     = portDIn;
      chipSelectPortLatch_nxt = portGIn;
    end
    else if (regWrEn)
    begin
      case (mpp_sel_e'(regSel))
        SEL_A_DATA: firstPortLatch_nxt          = regWrData;
        SEL_A_DIR:  firstPortDirection_nxt      = regWrData;
        SEL_B_DATA: highAddressPortLatch_nxt    = regWrData;
        SEL_C_DATA: dataBusPortLatch_nxt        = regWrData;
        SEL_C_DIR:  dataBusPortDirection_nxt    = regWrData;
        SEL_D_DATA: serialPortLatch_nxt         = regWrData[SERIAL_PORT_LATCH_W-1:0];
        SEL_D_DIR:  serialPortDirection_nxt     = regWrData[SERIAL_PORT_LATCH_W-1:0];
        SEL_F_DATA: lowAddressPortLatch_nxt     = regWrData;
        SEL_G_DATA: chipSelectPortLatch_nxt     = regWrData;
        SEL_G_DIR:  chipSelectPortDirection_nxt = regWrData;
        default:    firstPortLatch_nxt          = firstPortLatch_r; // port e and unused selects ignore writes
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      started_r                 <= 1'b0;
      mode_r                    <= MODE_SINGLE;
      firstPortLatch_r          <= LATCH_RST;
      firstPortDirection_r      <= DIR_RST;
      highAddressPortLatch_r    <= LATCH_RST;
      dataBusPortLatch_r        <= LATCH_RST;
      dataBusPortDirection_r    <= DIR_RST;
      serialPortLatch_r         <= DIRD_RST;
      serialPortDirection_r     <= DIRD_RST;
      lowAddressPortLatch_r     <= LATCH_RST;
      chipSelectPortLatch_r     <= LATCH_RST;
      chipSelectPortDirection_r <= DIR_RST;
    end
    else
    begin
      started_r                 <= started_nxt;
      mode_r                    <= mode_nxt;
      firstPortLatch_r          <= firstPortLatch_nxt;
      firstPortDirection_r      <= firstPortDirection_nxt;
      highAddressPortLatch_r    <= highAddressPortLatch_nxt;
      dataBusPortLatch_r        <= dataBusPortLatch_nxt;
      dataBusPortDirection_r    <= dataBusPortDirection_nxt;
      serialPortLatch_r         <= serialPortLatch_nxt;
      serialPortDirection_r     <= serialPortDirection_nxt;
      lowAddressPortLatch_r     <= lowAddressPortLatch_nxt;
      chipSelectPortLatch_r     <= chipSelectPortLatch_nxt;
      chipSelectPortDirection_r <= chipSelectPortDirection_nxt;
    end
  end

  // external bus sequencer, live only in expanded and test modes
  assign busIf.req     = busReq;
  assign busIf.write   = busWrite;
  assign busIf.addr    = busAddr;
  assign busIf.wdata   = busWrData;
  assign busIf.pinData = portCIn;
  assign busIf.enable  = expanded;

  mpp_ext_bus #(
    .PHASE (PHASE)
  ) u_ext_bus (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .bus      (busIf.seq)
  );

  // ownership of the shared pins
  always_comb
  begin
    cOwn   = {PORT_W{expanded}};
    cDrive = {PORT_W{busIf.dataOe}};
    c_open_drain_select   = cOpenDrainSelect && !expanded;
    gOwn   = {chipSelectEn, {(PORT_W - CS_W){1'b0}}};
    gVal   = {chipSelectVal, {(PORT_W - CS_W){1'b0}}};
    gDrive = gOwn;
  end

  mpp_pad #(
    .W (PORT_W)
  ) u_pad_a (
    .latch     (firstPortLatch_r),
    .dir       (firstPortDirection_r),
    .altOwn    (timerOcOwn),
    .altVal    (timerOcVal),
    .altDrive  (timerOcOwn),
    .openDrain (1'b0),
    .pin       (portAIn),
    .outVal    (aOut),
    .oeN       (aOeN),
    .readVal   (aRead)
  );

  mpp_pad #(
    .W (PORT_W)
  ) u_pad_c (
    .latch     (dataBusPortLatch_r),
    .dir       (dataBusPortDirection_r),
    .altOwn    (cOwn),
    .altVal    (busIf.ddata),
    .altDrive  (cDrive),
    .openDrain (c_open_drain_select),
    .pin       (portCIn),
    .outVal    (cOut),
    .oeN       (cOeN),
    .readVal   (cRead)
  );

  mpp_pad #(
    .W (SERIAL_PORT_LATCH_W)
  ) u_pad_d (
    .latch     (serialPortLatch_r),
    .dir       (serialPortDirection_r),
    .altOwn    (serialOwn),
    .altVal    (serialVal),
    .altDrive  (serialDrive),
    .openDrain (dOpenDrainSelect),
    .pin       (portDIn),
    .outVal    (dOut),
    .oeN       (dOeN),
    .readVal   (dRead)
  );

  mpp_pad #(
    .W (PORT_W)
  ) u_pad_g (
    .latch     (chipSelectPortLatch_r),
    .dir       (chipSelectPortDirection_r),
    .altOwn    (gOwn),
    .altVal    (gVal),
    .altDrive  (gDrive),
    .openDrain (gOpenDrainSelect),
    .pin       (portGIn),
    .outVal    (gOut),
    .oeN       (gOeN),
    .readVal   (gRead)
  );

  // read-back mux and pin output values
  always_comb
  begin
    rdData_nxt = rdData_r;
    if (regRdEn)
    begin
      case (mpp_sel_e'(regSel))
        SEL_A_DATA: rdData_nxt = aRead;
        SEL_A_DIR:  rdData_nxt = firstPortDirection_r;
        SEL_B_DATA: rdData_nxt = highAddressPortLatch_r;
        SEL_C_DATA: rdData_nxt = cRead;
        SEL_C_DIR:  rdData_nxt = dataBusPortDirection_r;
        SEL_D_DATA: rdData_nxt = {2'h0, dRead};
        SEL_D_DIR:  rdData_nxt = {2'h0, serialPortDirection_r};
        SEL_E_DATA: rdData_nxt = analogInputPort;
        SEL_F_DATA: rdData_nxt = lowAddressPortLatch_r;
        SEL_G_DATA: rdData_nxt = gRead;
        SEL_G_DIR:  rdData_nxt = chipSelectPortDirection_r;
        default:    rdData_nxt = 8'h00;
      endcase
    end
    bNxt  = expanded ? busIf.addrOut[ADDR_W-1:PORT_W] : highAddressPortLatch_r;
    fNxt  = expanded ? busIf.addrOut[PORT_W-1:0] : lowAddressPortLatch_r;
    rwNxt = expanded ? busIf.rw : 1'b1;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdData_r    <= LATCH_RST;
      rdValid_r   <= 1'b0;
      aOut_r      <= LATCH_RST;
      aOeN_r      <= ~DIR_RST;
      bOut_r      <= LATCH_RST;
      cOut_r      <= LATCH_RST;
      cOeN_r      <= ~DIR_RST;
      dOut_r      <= DIRD_RST;
      dOeN_r      <= ~DIRD_RST;
      fOut_r      <= LATCH_RST;
      gOut_r      <= LATCH_RST;
      gOeN_r      <= ~DIR_RST;
      e_r         <= 1'b0;
      rw_r        <= 1'b1;
      busReady_r  <= 1'b0;
      busDone_r   <= 1'b0;
      busRdData_r <= LATCH_RST;
    end
    else
    begin
      rdData_r    <= rdData_nxt;
      rdValid_r   <= regRdEn;
      aOut_r      <= aOut;
      aOeN_r      <= aOeN;
      bOut_r      <= bNxt;
      cOut_r      <= cOut;
      cOeN_r      <= cOeN;
      dOut_r      <= dOut;
      dOeN_r      <= dOeN;
      fOut_r      <= fNxt;
      gOut_r      <= gOut;
      gOeN_r      <= gOeN;
      e_r         <= busIf.eClk;
      rw_r        <= rwNxt;
      busReady_r  <= busIf.ready && expanded;
      busDone_r   <= busIf.done;
      busRdData_r <= busIf.rdata;
    end
  end

  assign regRdData  = rdData_r;
  assign regRdValid = rdValid_r;
  assign busReady   = busReady_r;
  assign busDone    = busDone_r;
  assign busRdData  = busRdData_r;
  assign portAOut   = aOut_r;
  assign portAOeN   = aOeN_r;
  assign portBOut   = bOut_r;
  assign portCOut   = cOut_r;
  assign portCOeN   = cOeN_r;
  assign portDOut   = dOut_r;
  assign portDOeN   = dOeN_r;
  assign portFOut   = fOut_r;
  assign portGOut   = gOut_r;
  assign portGOeN   = gOeN_r;
  assign eClkPin    = e_r;
  assign rwPin      = rw_r;
  assign opMode     = mode_r;
endmodule : mpp_ports

// ==== tb/mpp_ports_props.sv ====
// pin-level assertions for the multimode parallel ports
`timescale 1ns/1ns
module mpp_ports_props
  import mpp_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [3:0]  regSel,
  input wire logic [7:0]  regWrData,
  input wire logic        regRdValid,
  input wire logic        busReq,
  input wire logic        busWrite,
  input wire logic [15:0] busAddr,
  input wire logic        busReady,
  input wire logic [7:0]  timerOcOwn,
  input wire logic [7:0]  timerOcVal,
  input wire logic        cOpenDrainSelect,
  input wire logic [7:0]  portAOut,
  input wire logic [7:0]  portAOeN,
  input wire logic [7:0]  portBOut,
  input wire logic [7:0]  portCOut,
  input wire logic [7:0]  portCOeN,
  input wire logic [7:0]  portFOut,
  input wire logic        rwPin,
  input wire logic [1:0]  opMode
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  sequence rdTaken;
    busReq && busReady && !busWrite;
  endsequence
  sequence idleTaken;
    busReq && busReady && rwPin;
  endsequence
  read_valid_a: assert property (regRdEn |=> regRdValid)
    else $error("read valid missing");
  read_rw_a: assert property (rdTaken |=> rwPin [*7])
    else $error("rw low in read");
  write_rw_a: assert property ($fell(rwPin) |-> !rwPin [*4])
    else $error("rw rose in write");
  addr_pins_a: assert property (idleTaken |-> ##3 {portBOut, portFOut} == $past(busAddr, 3))
    else $error("address not on pins");
  dir_out_a: assert property (regWrEn && regSel == SEL_A_DIR && timerOcOwn == 8'h00 |-> ##2
    portAOeN == ~$past(regWrData, 2)) else $error("direction not on pins");
  timer_own_a: assert property ($past(arst_n) && timerOcOwn != 8'h00 && $stable(timerOcOwn) &&
    $stable(timerOcVal) |-> (((portAOut ^ timerOcVal) | portAOeN) & timerOcOwn) == 8'h00) else $error("timer pin wrong");
  c_drain_a: assert property (cOpenDrainSelect && $past(cOpenDrainSelect) && opMode == MODE_SINGLE |->
    (portCOut & ~portCOeN) == 8'h00) else $error("port c drove high");
  b_latch_a: assert property (opMode == MODE_SINGLE && !$past(regWrEn, 2) |-> $stable(portBOut))
    else $error("port b moved");
endmodule : mpp_ports_props
bind mpp_ports mpp_ports_props u_mpp_ports_props (.*);

// ==== tb/mpp_ext_mem.sv ====
// external memory answering bus cycles on the port pins
`timescale 1ns/1ns
module mpp_ext_mem (
  input wire logic       core_clk,
  input wire logic       eClkPin,
  input wire logic       rwPin,
  input wire logic       slow,
  input wire logic [7:0] addrLo,
  input wire logic [7:0] wrData,
  output logic     [7:0] rdData
);
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  logic       hiLate = 1'b0;
  logic       drive;
  always @(eClkPin)
    hiLate <= #8 eClkPin;
  assign drive = eClkPin && rwPin && (!slow || hiLate);
  assign rdData = drive ? mem[addrLo] : ~last;
  always @(posedge core_clk)
  begin
    if (drive)
      last <= mem[addrLo];
    if (eClkPin && !rwPin)
      mem[addrLo] <= wrData;
  end
endmodule : mpp_ext_mem

// ==== tb/testbench.sv ====
// self-checking bench for the multimode parallel ports
`timescale 1ns/1ns
module testbench;
  import mpp_pkg::*;
  logic core_clk = 1'b0, arst_n = 1'b0, modeSelectPinLow = 1'b0, modeSelectPinHigh = 1'b1;
  logic regWrEn = 1'b0, regRdEn = 1'b0, busReq = 1'b0, busWrite = 1'b0, slow = 1'b0, rwPrev = 1'b1;
  logic dOpenDrainSelect = 1'b0, cOpenDrainSelect = 1'b0, gOpenDrainSelect = 1'b0;
  logic [3:0] regSel = 4'h0, chipSelectEn = 4'h0, chipSelectVal = 4'h0;
  logic [7:0] regWrData = 8'h00, busWrData = 8'h00, timerOcOwn = 8'h00, timerOcVal = 8'h00;
  logic [7:0] analogInputPort = 8'h00, aDrv = 8'h00, gDrv = 8'h00, l = 8'h00, d = 8'h00;
  logic [5:0] serialOwn = 6'h00, serialVal = 6'h00, serialDrive = 6'h00, dDrv = 6'h00;
  logic [15:0] busAddr = 16'h0000;
  logic [7:0] regRdData, busRdData, portAOut, portAOeN, portBOut, portCOut, portCOeN, portFOut;
  logic [7:0] portGOut, portGOeN, memData;
  logic [5:0] portDOut, portDOeN;
  logic [1:0] opMode;
  logic regRdValid, busReady, busDone, eClkPin, rwPin;
  int bad_count = 0, n_tests = 0, i, rises;
  wire [7:0] portAIn = ~portAOeN & portAOut | portAOeN & aDrv;
  wire [7:0] portCIn = ~portCOeN & portCOut | portCOeN & memData;
  wire [7:0] portGIn = ~portGOeN & portGOut | portGOeN & gDrv;
  wire [5:0] portDIn = ~portDOeN & portDOut | portDOeN & dDrv;
  mpp_ports #(.PHASE(2)) u_mpp_ports (.*);
  mpp_ext_mem u_mpp_ext_mem (.core_clk, .eClkPin, .rwPin, .slow, .addrLo(portFOut), .wrData(portCOut),
    .rdData(memData));
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    rwPrev <= rwPin;
    if (!rwPrev && rwPin)
      rises++;
  end
  function automatic logic [7:0] expA(input logic [7:0] own, val, lat, dir, pin);
    return own & val | ~own & (dir & lat | ~dir & pin);
  endfunction : expA
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic waitFor(ref logic s);
    for (i = 0; i < 60 && s !== 1'b1; i++)
      @(negedge core_clk);
    if (i == 60)
    begin
      bad_count++;
      stop_test;
    end
  endtask : waitFor
  task automatic rst(input logic [1:0] m);
    arst_n = 1'b0;
    {modeSelectPinHigh, modeSelectPinLow} = m;
    repeat (16) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask : rst
  task automatic wr(input logic [3:0] s, input logic [7:0] v);
    {regWrEn, regSel, regWrData} = {1'b1, s, v};
    @(negedge core_clk);
    regWrEn = 1'b0;
    @(negedge core_clk);
  endtask : wr
  task automatic rd(input logic [3:0] s, input logic [7:0] e);
    {regRdEn, regSel} = {1'b1, s};
    @(negedge core_clk);
    regRdEn = 1'b0;
    @(negedge core_clk);
    chk("read", regRdData, e);
  endtask : rd
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] v);
    waitFor(busReady);
    {busReq, busWrite, busAddr, busWrData} = {1'b1, w, a, v};
    @(negedge core_clk);
    busReq = 1'b0;
    @(negedge core_clk);
  endtask : bus
  initial
  begin
    i = $urandom(32'h0000_cc54);
    rst(MODE_SINGLE);
    chk("aOeN", portAOeN, 8'hff);
    chk("mode", opMode, MODE_SINGLE);
    rd(SEL_A_DIR, 8'h00);
    for (int k = 0; k < 40; k++)
    begin
      {l, d, aDrv, gDrv} = $urandom;
      {timerOcVal, chipSelectEn, chipSelectVal, serialOwn, serialVal} = 28'($urandom);
      {serialDrive, cOpenDrainSelect, gOpenDrainSelect, dOpenDrainSelect, slow} = 10'($urandom);
      {analogInputPort, timerOcOwn} = 16'($urandom);
      dDrv = 6'($urandom);
      if (k < 3)
        timerOcOwn = 8'h00;
      wr(SEL_A_DATA, l);
      wr(SEL_A_DIR, d);
      wr(SEL_B_DATA, ~l);
      wr(SEL_F_DATA, d);
      wr(SEL_C_DATA, l);
      wr(SEL_C_DIR, d);
      wr(SEL_G_DATA, l);
      wr(SEL_G_DIR, d);
      chk("aOeN", portAOeN, ~(d | timerOcOwn));
      chk("aOut", portAOut & (d | timerOcOwn), expA(timerOcOwn, timerOcVal, l, 8'hff, 8'h00) & (d | timerOcOwn));
      chk("bOut", portBOut, ~l);
      chk("fOut", portFOut, d);
      chk("cs", {4'h0, (portGOut[7:4] | portGOeN[7:4]) & chipSelectEn}, {4'h0, chipSelectVal & chipSelectEn});
      rd(SEL_A_DATA, expA(timerOcOwn, timerOcVal, l, d, aDrv));
      rd(SEL_B_DATA, ~l);
      rd(SEL_E_DATA, analogInputPort);
    end
    rst(MODE_EXPAND);
    chk("mode", opMode, MODE_EXPAND);
    chk("cOeN", portCOeN, 8'hff);
    wr(SEL_F_DATA, 8'h5a);
    rd(SEL_F_DATA, 8'h5a);
    rises = 0;
    bus(1'b1, 16'h1234, 8'hc3);
    bus(1'b1, 16'h1235, 8'h3c);
    waitFor(rwPin);
    @(negedge core_clk);
    chk("rises", 8'(rises), 8'h01);
    slow = 1'b0;
    bus(1'b0, 16'h1234, 8'h00);
    waitFor(busDone);
    chk("busRd", busRdData, 8'hc3);
    slow = 1'b1;
    bus(1'b0, 16'h1235, 8'h00);
    waitFor(busDone);
    chk("busRd", busRdData, 8'h3c);
    stop_test;
  end
endmodule : testbench
